// ==== hw/ffbank_pkg.sv ====
package ffbank_pkg;
    // Clock and timing figures
    localparam int CLK_PERIOD_NS = 25;
    localparam int MIN_FORCE_NS = 100;
    localparam int MIN_COND_NS = 400;
    localparam int MIN_IDLE_NS = 400;
    localparam int MIN_CARRY_CLR_NS = 400;
    localparam int MIN_PULSE_NS = 100;
    localparam int MAX_RATE_KHZ = 2000;
    localparam int MIN_PERIOD_NS = 1000000 / MAX_RATE_KHZ;
    // Round a least time up to whole clock cycles
    function automatic int ns_to_cyc(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction
    // Least times round up to whole cycles
    localparam int FORCE_CYC = ns_to_cyc(MIN_FORCE_NS);
    localparam int COND_CYC = ns_to_cyc(MIN_COND_NS);
    localparam int IDLE_CYC = ns_to_cyc(MIN_IDLE_NS);
    localparam int CARRY_CLR_CYC = ns_to_cyc(MIN_CARRY_CLR_NS);
    localparam int PULSE_CYC = ns_to_cyc(MIN_PULSE_NS);
    localparam int PERIOD_CYC = ns_to_cyc(MIN_PERIOD_NS);
    localparam int CNT_W = 6;
    // Cell counts per variant
    localparam int DUAL_CELLS = 2;
    localparam int TRIPLE_CELLS = 3;
    localparam int QUAD_CELLS = 4;
    localparam int MAX_CELLS = 4;
    localparam logic [MAX_CELLS-1:0] CELL_RST = 4'h0;
    typedef enum logic [1:0] {
        VAR_DUAL,
        VAR_TRIPLE,
        VAR_QUAD
    } variant_t;
endpackage

// ==== hw/ffbank_if.sv ====
`timescale 1ns/1ps
// Input pins are active high in the logic model: 1 = ground (asserted)
interface ffbank_if;
    import ffbank_pkg::*;
    logic [MAX_CELLS-1:0] set_n;     // 1 = direct set active
    logic [MAX_CELLS-1:0] clr_n;     // 1 = direct clear active
    logic [MAX_CELLS-1:0] one_gate;  // Set-side gate level, 1 = enabled
    logic [MAX_CELLS-1:0] zero_gate; // Clear-side gate level, 1 = enabled
    logic [MAX_CELLS-1:0] trig;      // Trigger, rising = ground edge
    logic [MAX_CELLS-1:0] pull_one;  // Collector pull on true output
    logic [MAX_CELLS-1:0] pull_zero; // Collector pull on complement output
    logic [MAX_CELLS-1:0] q;         // True output, 1 = negative level
    logic [MAX_CELLS-1:0] q_bar;     // Complement output
    modport device (
        input set_n, clr_n, one_gate, zero_gate, trig, pull_one, pull_zero,
        output q, q_bar
    );
    modport driver (
        output set_n, clr_n, one_gate, zero_gate, trig, pull_one, pull_zero,
        input q, q_bar
    );
endinterface

// ==== hw/gated_flip_flop_bank.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Dual: two cells, own clears, shared set
// - Direct inputs need at least 100 ns
// - Set and clear together: both outputs inactive
// - Gate accepts trigger only when level grounded
// - Gate level stable 400 ns before trigger
// - Tied gates make cell toggle
// - Trigger on rising edge, up to 2 mc
// - Trigger idle 400 ns before each event
// - Counter clear or set pulses 400 ns
// - Unused direct inputs held inactive
// - Triple: three cells, clear, one gate
// - Quad: four cells, two share clear
// - Set gives true one; clear gives zero
// - Forced output state is held afterwards
module gated_flip_flop_bank #(
    parameter ffbank_pkg::variant_t VARIANT = ffbank_pkg::VAR_DUAL
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link to driving logic
    ffbank_if.device link
);
    import ffbank_pkg::*;

    localparam int NCELL = (VARIANT == VAR_DUAL) ? DUAL_CELLS :
                           (VARIANT == VAR_TRIPLE) ? TRIPLE_CELLS : QUAD_CELLS;
    // Unused cells show neither output
    localparam logic [MAX_CELLS-1:0] USED_CELLS =
        MAX_CELLS'((1 << NCELL) - 1);

    logic [MAX_CELLS-1:0] meta_set, sync_set, meta_clr, sync_clr;
    logic [MAX_CELLS-1:0] meta_one, sync_one, meta_zero, sync_zero;
    logic [MAX_CELLS-1:0] meta_trig, sync_trig, trig_prev_ff;
    logic [MAX_CELLS-1:0] meta_po, sync_po, meta_pz, sync_pz;
    logic [MAX_CELLS-1:0] set_eff, clr_eff, edge_hit;
    logic [MAX_CELLS-1:0] state_ff, nxt_state;
    logic [MAX_CELLS-1:0] q_ff, qb_ff, nxt_q, nxt_qb;

    // Direct set and clear, two-stage synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_set <= '0;
            sync_set <= '0;
            meta_clr <= '0;
            sync_clr <= '0;
        end else begin
            meta_set <= link.set_n;
            sync_set <= meta_set;
            meta_clr <= link.clr_n;
            sync_clr <= meta_clr;
        end
    end

    // Gate levels, two-stage synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_one <= '0;
            sync_one <= '0;
            meta_zero <= '0;
            sync_zero <= '0;
        end else begin
            meta_one <= link.one_gate;
            sync_one <= meta_one;
            meta_zero <= link.zero_gate;
            sync_zero <= meta_zero;
        end
    end

    // Trigger, two-stage synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_trig <= '0;
            sync_trig <= '0;
        end else begin
            meta_trig <= link.trig;
            sync_trig <= meta_trig;
        end
    end

    // Collector pulls, two-stage synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_po <= '0;
            sync_po <= '0;
            meta_pz <= '0;
            sync_pz <= '0;
        end else begin
            meta_po <= link.pull_one;
            sync_po <= meta_po;
            meta_pz <= link.pull_zero;
            sync_pz <= meta_pz;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev_ff <= '0;
        end else begin
            trig_prev_ff <= sync_trig;
        end
    end

    // Per-variant wiring of the direct inputs
    always_comb begin
        set_eff = '0;
        clr_eff = '0;
        case (VARIANT)
            VAR_DUAL: begin
                set_eff[1:0] = {2{sync_set[0]}};
                clr_eff[1:0] = sync_clr[1:0];
            end
            VAR_TRIPLE: begin
                clr_eff[2:0] = sync_clr[2:0];
            end
            VAR_QUAD: begin
                set_eff = sync_set;
                clr_eff = {sync_clr[3:2], sync_clr[1], sync_clr[1]};
            end
            default: begin
                set_eff = '0;
                clr_eff = '0;
            end
        endcase
    end

    // One-cycle pulse on each rising trigger
    assign edge_hit = sync_trig & ~trig_prev_ff;

    // Gated trigger action for one cell; quad cells have no gates
    function automatic logic gate_next(input logic cur, input logic one,
                                       input logic zero);
        logic res;
        res = cur;
        case (VARIANT)
            VAR_DUAL: begin
                // Gates qualified by present state: tied gates toggle
                if (!cur && one) res = 1'b1;
                else if (cur && zero) res = 1'b0;
            end
            VAR_TRIPLE: begin
                // Read-in gate loads a one
                if (one) res = 1'b1;
            end
            default: res = cur;
        endcase
        return res;
    endfunction

    // Cell state update: direct inputs, then collector pulls, then trigger
    always_comb begin
        nxt_state = state_ff;
        for (int i = 0; i < NCELL; i++) begin
            if (set_eff[i] || clr_eff[i]) begin
                if (set_eff[i] && !clr_eff[i]) nxt_state[i] = 1'b1;
                else if (clr_eff[i] && !set_eff[i]) nxt_state[i] = 1'b0;
            end else if (sync_po[i] && !sync_pz[i]) begin
                nxt_state[i] = 1'b1;
            end else if (sync_pz[i] && !sync_po[i]) begin
                nxt_state[i] = 1'b0;
            end else if (edge_hit[i]) begin
                nxt_state[i] = gate_next(state_ff[i], sync_one[i],
                                         sync_zero[i]);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CELL_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs, registered
    always_comb begin
        nxt_q = '0;
        nxt_qb = '0;
        for (int i = 0; i < NCELL; i++) begin
            if (set_eff[i] && clr_eff[i]) begin
                nxt_q[i] = 1'b1;
                nxt_qb[i] = 1'b1;
            end else begin
                nxt_q[i] = nxt_state[i];
                nxt_qb[i] = ~nxt_state[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= CELL_RST & USED_CELLS;
            qb_ff <= ~CELL_RST & USED_CELLS;
        end else begin
            q_ff <= nxt_q;
            qb_ff <= nxt_qb;
        end
    end

    assign link.q = q_ff;
    assign link.q_bar = qb_ff;

endmodule // gated_flip_flop_bank

// ==== hw/ffbank_driver.sv ====
`timescale 1ns/1ps
// Driving logic: turns one-cycle user requests into timed pin activity
module ffbank_driver (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link to cells
    ffbank_if.driver link,
    // User requests
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] req_set,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] req_clr,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] req_trig,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] gate_one,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] gate_zero,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] req_pull_one,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] req_pull_zero,
    // User status
    output logic busy,
    output logic [ffbank_pkg::MAX_CELLS-1:0] q_seen
);
    import ffbank_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FORCE, ST_COND, ST_PULSE, ST_REST
    } drv_state_t;

    drv_state_t st_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [MAX_CELLS-1:0] set_ff, clr_ff, one_ff, zero_ff, trig_ff;
    logic [MAX_CELLS-1:0] po_ff, pz_ff, pend_ff, meta_q, q_ff;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    // Sequencer: direct and collector force held 400 ns, else gate setup,
    // 100 ns trigger, then rest so period meets the 2 mc limit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            cnt_ff <= '0;
            set_ff <= '0;
            clr_ff <= '0;
            one_ff <= '0;
            zero_ff <= '0;
            trig_ff <= '0;
            po_ff <= '0;
            pz_ff <= '0;
            pend_ff <= '0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (|(req_set | req_clr | req_pull_one |
                          req_pull_zero)) begin
                        set_ff <= req_set;
                        clr_ff <= req_clr;
                        po_ff <= req_pull_one;
                        pz_ff <= req_pull_zero;
                        cnt_ff <= cyc(CARRY_CLR_CYC);
                        st_ff <= ST_FORCE;
                    end else if (|req_trig) begin
                        one_ff <= gate_one;
                        zero_ff <= gate_zero;
                        pend_ff <= req_trig;
                        cnt_ff <= cyc(COND_CYC);
                        st_ff <= ST_COND;
                    end
                end
                ST_FORCE: begin
                    if (cnt_ff == '0) begin
                        set_ff <= '0;
                        clr_ff <= '0;
                        po_ff <= '0;
                        pz_ff <= '0;
                        cnt_ff <= cyc(IDLE_CYC);
                        st_ff <= ST_REST;
                    end else cnt_ff <= cnt_ff - 1'b1;
                end
                ST_COND: begin
                    if (cnt_ff == '0) begin
                        trig_ff <= pend_ff;
                        cnt_ff <= cyc(PULSE_CYC);
                        st_ff <= ST_PULSE;
                    end else cnt_ff <= cnt_ff - 1'b1;
                end
                ST_PULSE: begin
                    if (cnt_ff == '0) begin
                        trig_ff <= '0;
                        cnt_ff <= cyc(IDLE_CYC);
                        st_ff <= ST_REST;
                    end else cnt_ff <= cnt_ff - 1'b1;
                end
                ST_REST: begin
                    if (cnt_ff == '0) begin
                        one_ff <= '0;
                        zero_ff <= '0;
                        st_ff <= ST_IDLE;
                    end else cnt_ff <= cnt_ff - 1'b1;
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // Cell outputs sampled through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q_ff <= '0;
        end else begin
            meta_q <= link.q;
            q_ff <= meta_q;
        end
    end

    assign link.set_n = set_ff;
    assign link.clr_n = clr_ff;
    assign link.one_gate = one_ff;
    assign link.zero_gate = zero_ff;
    assign link.trig = trig_ff;
    assign link.pull_one = po_ff;
    assign link.pull_zero = pz_ff;
    assign busy = (st_ff != ST_IDLE);
    assign q_seen = q_ff;

endmodule // ffbank_driver

// ==== test/ffbank_monitor.sv ====
`timescale 1ns/1ps
module ffbank_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins from the driving side
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] set_n,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] clr_n,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] one_gate,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] zero_gate,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] trig,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] pull_one,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] pull_zero,
    // Cell outputs
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] q,
    input wire logic [ffbank_pkg::MAX_CELLS-1:0] q_bar
);
    import ffbank_pkg::*;
    logic [CNT_W-1:0] gate_cnt_ff, idle_cnt_ff, clr_cnt_ff;
    // Cycles since cell 0 gate levels last moved
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) gate_cnt_ff <= '0;
        else if ($changed(one_gate[0]) || $changed(zero_gate[0]))
            gate_cnt_ff <= '0;
        else if (gate_cnt_ff != '1) gate_cnt_ff <= gate_cnt_ff + 1'b1;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) idle_cnt_ff <= '0;
        else if (trig[0]) idle_cnt_ff <= '0;
        else if (idle_cnt_ff != '1) idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) clr_cnt_ff <= '0;
        else if (!clr_n[1]) clr_cnt_ff <= '0;
        else if (clr_cnt_ff != '1) clr_cnt_ff <= clr_cnt_ff + 1'b1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_both_inactive: assert property (
        (set_n[0] && clr_n[0])[*5] |-> q[0] && q_bar[0])
        else $error("set and clear together left an output active");
    a_set_one: assert property (
        (set_n[0] && !clr_n[0])[*5] |-> q[0] && !q_bar[0])
        else $error("direct set did not give a one");
    a_clear_zero: assert property (
        (clr_n[1] && !set_n[0])[*5] |-> !q[1] && q_bar[1])
        else $error("direct clear did not give a zero");
    a_gate_closed: assert property (
        $rose(trig[0]) && !one_gate[0] && !zero_gate[0]
        |=> $stable(q[0])[*4])
        else $error("closed gate let a trigger through");
    a_tied_toggle: assert property (
        $rose(trig[0]) && one_gate[0] && zero_gate[0]
        |-> ##5 q[0] != $past(q[0], 5))
        else $error("tied gates did not toggle the cell");
    a_gate_setup: assert property (
        $rose(trig[0]) |-> gate_cnt_ff >= COND_CYC - 1)
        else $error("gate level moved too close to trigger");
    a_trig_idle: assert property (
        $rose(trig[0]) |-> idle_cnt_ff >= IDLE_CYC - 1)
        else $error("trigger not idle long enough");
    a_trig_width: assert property (
        $rose(trig[0]) |-> trig[0][*4])
        else $error("trigger pulse too short");
    a_clear_width: assert property (
        $fell(clr_n[1]) |-> clr_cnt_ff >= CARRY_CLR_CYC - 1)
        else $error("clear pulse too short");
    a_unused_low: assert property (
        q[3:2] == 2'h0 && q_bar[3:2] == 2'h0)
        else $error("unused dual cell drives an output");
    a_pull_hold: assert property (
        $fell(pull_one[0]) && !clr_n[0] && !set_n[0] |-> q[0][*4])
        else $error("forced one not held");
    c_toggle: cover property ($rose(trig[0]) && one_gate[0] && zero_gate[0]);
    c_both: cover property (set_n[0] && clr_n[0]);
    c_pull: cover property ($fell(pull_one[0]));
endmodule // ffbank_monitor

// ==== test/test_gated_flip_flop_bank.sv ====
`timescale 1ns/1ps
module test_gated_flip_flop_bank;
    import ffbank_pkg::*;
    logic clock, rst_n;
    logic [3:0] r_set, r_clr, r_trig, g_one, g_zero, p_one, p_zero;
    logic [3:0] qv [3];
    logic [3:0] qbv [3];
    logic [3:0] qsv [3];
    logic [3:0] st [3];
    logic [3:0] hm [3];
    logic [2:0] bsy;
    int errors, n_checks;
    logic [31:0] x;
    genvar v;
    for (v = 0; v < 3; v++) begin : g
        ffbank_if link();
        ffbank_driver ffbank_driver_inst(.clock(clock), .rst_n(rst_n),
            .link(link), .req_set(r_set), .req_clr(r_clr),
            .req_trig(r_trig), .gate_one(g_one), .gate_zero(g_zero),
            .req_pull_one(p_one), .req_pull_zero(p_zero),
            .busy(bsy[v]), .q_seen(qsv[v]));
        gated_flip_flop_bank #(.VARIANT(variant_t'(v)))
            gated_flip_flop_bank_inst(.clock(clock), .rst_n(rst_n),
            .link(link));
        assign qv[v] = link.q;
        assign qbv[v] = link.q_bar;
        if (v == 0) begin : m
            ffbank_monitor ffbank_monitor_inst(.clock(clock),
                .rst_n(rst_n), .set_n(link.set_n), .clr_n(link.clr_n),
                .one_gate(link.one_gate), .zero_gate(link.zero_gate),
                .trig(link.trig), .pull_one(link.pull_one),
                .pull_zero(link.pull_zero), .q(link.q), .q_bar(link.q_bar));
        end
    end
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic end_sim();
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Used cells follow the model, unused cells read low
    task automatic check();
        logic [3:0] mk;
        for (int k = 0; k < 3; k++) begin
            mk = 4'hf >> (2 - k);
            cmp(qv[k], (st[k] | hm[k]) & mk);
            cmp(qbv[k], (~st[k] | hm[k]) & mk);
            cmp(qsv[k], (st[k] | hm[k]) & mk);
        end
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        st = '{default: 4'h0};
        hm = '{default: 4'h0};
    endtask
    task automatic op(input logic [3:0] s, c, t, go, gz, po, pz);
        logic si, ci;
        int k;
        @(negedge clock);
        {r_set, r_clr, r_trig, g_one, g_zero, p_one, p_zero} =
            {s, c, t, go, gz, po, pz};
        @(negedge clock);
        {r_set, r_clr, r_trig, g_one, g_zero, p_one, p_zero} = '0;
        for (int w = 0; w < 3; w++) begin
            for (int i = 0; i < w + 2; i++) begin
                si = (w == 1) ? 1'b0 : ((w == 0) ? s[0] : s[i]);
                ci = (w == 2 && i < 2) ? c[1] : c[i];
                if (si && ci) hm[w][i] = 1'b1;
                else if (si) st[w][i] = 1'b1;
                else if (ci) st[w][i] = 1'b0;
                else if (po[i] && !pz[i]) st[w][i] = 1'b1;
                else if (pz[i] && !po[i]) st[w][i] = 1'b0;
                else if (t[i] && w == 0 && (st[w][i] ? gz[i] : go[i]))
                    st[w][i] = ~st[w][i];
                else if (t[i] && w == 1 && go[i]) st[w][i] = 1'b1;
            end
        end
        if ((hm[0] | hm[1] | hm[2]) != 4'h0) begin
            repeat (10) @(negedge clock);
            check();
        end
        k = 0;
        while (bsy !== 3'b000 && k < 100) begin
            @(negedge clock);
            k++;
        end
        if (k == 100) begin
            errors++;
            end_sim();
        end
        hm = '{default: 4'h0};
        repeat (6) @(negedge clock);
        check();
    endtask
    initial begin
        errors = 0;
        n_checks = 0;
        {r_set, r_clr, r_trig, g_one, g_zero, p_one, p_zero} = '0;
        void'($urandom(32'h240a));
        do_reset();
        check();
        op(4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        op(4'h0, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        op(4'h0, 4'h0, 4'hf, 4'hf, 4'hf, 4'h0, 4'h0);
        op(4'h0, 4'h0, 4'hf, 4'hf, 4'hf, 4'h0, 4'h0);
        op(4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0);
        op(4'h0, 4'h0, 4'hf, 4'h5, 4'ha, 4'h0, 4'h0);
        op(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hf, 4'h0);
        op(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h5);
        op(4'hf, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        repeat (24) begin
            x = $urandom;
            case (x[14:12] % 5)
                0: op(x[3:0], 0, 0, 0, 0, 0, 0);
                1: op(0, x[3:0], 0, 0, 0, 0, 0);
                2: op(0, 0, x[3:0], x[7:4], x[11:8], 0, 0);
                3: op(0, 0, 0, 0, 0, x[3:0], 0);
                default: op(0, 0, 0, 0, 0, 0, x[3:0]);
            endcase
        end
        do_reset();
        check();
        end_sim();
    end
endmodule // test_gated_flip_flop_bank
